// file: hdl/gain_offset_defs.vh
// Register indices, field layouts, reset values and datapath constants of the gain and offset bank.
`ifndef GAIN_OFFSET_DEFS_VH
`define GAIN_OFFSET_DEFS_VH
`define IDX_EIGHTH_GAIN 8'h9d
`define IDX_CH0_OFFSET 8'h9e
`define IDX_CH1_OFFSET 8'h9f
`define IDX_CH2_OFFSET 8'ha0
`define IDX_CH3_OFFSET 8'ha1
`define IDX_STEP_WEIGHT 8'ha7
`define IDX_SEQUENCE 8'ha9
`define IDX_STATUS 8'haa
`define RST_EIGHTH_GAIN 8'h3c
`define RST_OFFSET 8'h00
`define RST_STEP_SELECT 2'h0
`define RST_SEQUENCE 24'hfac688
`define STEP_SEL_LSB 3
`define STEP_SEL_MSB 4
`define SEQ_WIDTH 24
`define UNITY_GAIN 8'h20
`define GAIN_FRAC_BITS 5
`define QUARTER_BITS 2
`define STATUS_SAT_BIT 0
`define SLOT_GAIN 3'h7
`endif

// file: hdl/sample_adjust.v
// Two-stage sample gain, weighted offset and saturation pipeline.
`timescale 1ns/1ps
`default_nettype none
`include "gain_offset_defs.vh"
module sample_adjust #(
  parameter SW = 12
) (
  input wire pclk,
  input wire presetn,
  input wire in_valid,
  input wire [SW-1:0] in_sample,
  input wire [2:0] in_slot,
  input wire [7:0] gain_code,
  input wire [7:0] offset_code,
  input wire [1:0] step_sel,
  output reg out_valid_q,
  output reg [SW-1:0] out_sample_q,
  output reg [2:0] out_slot_q,
  output reg out_sat_q
);
  localparam TW = SW + 4;
  localparam PW = TW + 8;
  localparam SH = `GAIN_FRAC_BITS + `QUARTER_BITS;
  localparam RW = PW - SH;

  reg v1_q;
  reg [2:0] slot1_q;
  reg signed [TW-1:0] t1_q;
  reg signed [7:0] g1_q;
  wire signed [TW-1:0] sample_q4;
  wire signed [TW-1:0] offset_q4;
  wire signed [PW-1:0] prod;
  wire signed [RW-1:0] scaled;
  wire signed [RW-1:0] max_v;
  wire signed [RW-1:0] min_v;
  wire over;
  wire under;

  ////////////////////////////////////////////////////////////////////////
  // Work in quarter-LSb units so the smallest offset step stays exact.
  assign sample_q4 = $signed({{2{in_sample[SW-1]}}, in_sample, 2'b00});
  // RULE_04: signed offset code.
  // RULE_06: zero adds nothing.
  assign offset_q4 = $signed({{(TW-8){offset_code[7]}}, offset_code}) <<< step_sel;

  // RULE_08: first stage sum.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v1_q <= 1'b0;
      slot1_q <= 3'h0;
      t1_q <= {TW{1'b0}};
      g1_q <= 8'h00;
    end else begin
      v1_q <= in_valid;
      slot1_q <= in_slot;
      t1_q <= sample_q4 + offset_q4;
      g1_q <= gain_code;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RULE_05: offset scaled by gain.
  assign prod = t1_q * g1_q;
  assign scaled = prod[PW-1:SH];
  assign max_v = $signed({{(RW-SW+1){1'b0}}, {(SW-1){1'b1}}});
  assign min_v = $signed({{(RW-SW+1){1'b1}}, {(SW-1){1'b0}}});
  assign over = scaled > max_v;
  assign under = scaled < min_v;

  // RULE_08: saturate to output range.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_valid_q <= 1'b0;
      out_sample_q <= {SW{1'b0}};
      out_slot_q <= 3'h0;
      out_sat_q <= 1'b0;
    end else begin
      out_valid_q <= v1_q;
      out_slot_q <= slot1_q;
      out_sat_q <= v1_q & (over | under);
      if (over) begin
        out_sample_q <= max_v[SW-1:0];
      end else if (under) begin
        out_sample_q <= min_v[SW-1:0];
      end else begin
        out_sample_q <= scaled[SW-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/channel_gain_offset_regs.v
// APB register bank and sample adjustment control for channel gain and offset.
`timescale 1ns/1ps
`default_nettype none
`include "gain_offset_defs.vh"
// Summary of operation
// RULE_01: eighth-slot gain code, 1/32 steps, resets 0x3c.
// RULE_02: gain follows eighth sequence slot, not input.
// RULE_03: four offset codes at 0x9e, reset zero.
// RULE_04: offset codes are two's complement.
// RULE_05: offset times selected weight step.
// RULE_06: zero code none, one code one step.
// RULE_07: weight 11/10/01/00 gives 2,1,1/2,1/4 LSb.
// RULE_08: gain, add offset, saturate to output; the code adds the offset before the gain.
module channel_gain_offset_regs #(
  parameter SW = 12,
  parameter ADDR_W = 12
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  input wire sample_valid,
  input wire [SW-1:0] sample_data,
  input wire [2:0] sample_slot,
  output wire adj_valid,
  output wire [SW-1:0] adj_data,
  output wire [2:0] adj_slot,
  output reg [2:0] adj_input
);
  reg [7:0] eighth_gain_code_q;
  reg [7:0] offset_q [0:3];
  reg [1:0] offset_step_select_q;
  reg [`SEQ_WIDTH-1:0] channel_sequence_field_q;
  reg sat_sticky_q;
  reg [31:0] rdata_d;
  reg hit_d;
  reg [7:0] gain_sel;
  reg [7:0] offset_sel;
  wire [ADDR_W-3:0] index;
  wire setup;
  wire wr_en;
  wire sat_pulse;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode: indices sit four bytes apart, misaligned addresses miss.
  assign index = paddr[ADDR_W-1:2];
  assign setup = psel & ~penable;
  // Zero wait states: read data was latched in the setup cycle.
  assign pready = psel & penable;
  assign wr_en = psel & penable & pwrite & ~pslverr;

  // Read mux and address hit, evaluated for the setup cycle.
  always @* begin
    rdata_d = 32'h00000000;
    hit_d = (paddr[1:0] == 2'h0);
    case (index)
      `IDX_EIGHTH_GAIN: rdata_d[7:0] = eighth_gain_code_q;
      `IDX_CH0_OFFSET: rdata_d[7:0] = offset_q[0];
      `IDX_CH1_OFFSET: rdata_d[7:0] = offset_q[1];
      `IDX_CH2_OFFSET: rdata_d[7:0] = offset_q[2];
      `IDX_CH3_OFFSET: rdata_d[7:0] = offset_q[3];
      `IDX_STEP_WEIGHT: rdata_d[`STEP_SEL_MSB:`STEP_SEL_LSB] = offset_step_select_q;
      `IDX_SEQUENCE: rdata_d[`SEQ_WIDTH-1:0] = channel_sequence_field_q;
      `IDX_STATUS: rdata_d[`STATUS_SAT_BIT] = sat_sticky_q;
      default: hit_d = 1'b0;
    endcase
  end

  // Read data and error are registered so the bus sees flip-flop outputs.
  // A refused access must not leak a register through a misaligned alias.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= (pwrite | ~hit_d) ? 32'h00000000 : rdata_d;
      pslverr <= ~hit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RULE_01: gain register write.
  // RULE_07: weight field write.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eighth_gain_code_q <= `RST_EIGHTH_GAIN;
      offset_step_select_q <= `RST_STEP_SELECT;
      channel_sequence_field_q <= `RST_SEQUENCE;
    end else if (wr_en) begin
      if (index == `IDX_EIGHTH_GAIN && pstrb[0]) begin
        eighth_gain_code_q <= pwdata[7:0];
      end
      if (index == `IDX_STEP_WEIGHT && pstrb[0]) begin
        offset_step_select_q <= pwdata[`STEP_SEL_MSB:`STEP_SEL_LSB];
      end
      if (index == `IDX_SEQUENCE) begin
        if (pstrb[0]) begin
          channel_sequence_field_q[7:0] <= pwdata[7:0];
        end
        if (pstrb[1]) begin
          channel_sequence_field_q[15:8] <= pwdata[15:8];
        end
        if (pstrb[2]) begin
          channel_sequence_field_q[23:16] <= pwdata[23:16];
        end
      end
    end
  end

  // RULE_03: four offset registers.
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_off
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          offset_q[ch] <= `RST_OFFSET;
        end else if (wr_en && pstrb[0] && index == `IDX_CH0_OFFSET + ch) begin
          offset_q[ch] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // Saturation is sticky; a new event in the clearing cycle wins over the clear.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sat_sticky_q <= 1'b0;
    end else if (sat_pulse) begin
      sat_sticky_q <= 1'b1;
    end else if (wr_en && pstrb[0] && index == `IDX_STATUS && pwdata[`STATUS_SAT_BIT]) begin
      sat_sticky_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // RULE_02: gain by sequence slot.
  // Slots whose gain lives elsewhere pass at unity; slots 4 to 7 take no offset here.
  always @* begin
    gain_sel = (sample_slot == `SLOT_GAIN) ? eighth_gain_code_q : `UNITY_GAIN;
    offset_sel = sample_slot[2] ? 8'h00 : offset_q[sample_slot[1:0]];
  end

  sample_adjust #(
    .SW(SW)
  ) u_adjust (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(sample_valid),
    .in_sample(sample_data),
    .in_slot(sample_slot),
    .gain_code(gain_sel),
    .offset_code(offset_sel),
    .step_sel(offset_step_select_q),
    .out_valid_q(adj_valid),
    .out_sample_q(adj_data),
    .out_slot_q(adj_slot),
    .out_sat_q(sat_pulse)
  );

  // Report which physical input the sequence maps to the incoming sample slot, one edge later.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adj_input <= 3'h0;
    end else begin
      adj_input <= channel_sequence_field_q[sample_slot*3 +: 3];
    end
  end
endmodule
`default_nettype wire

// file: verification/gain_offset_monitor.sv
// Port-level assertions for the gain and offset bank.
`timescale 1ns/1ps
`default_nettype none
module gain_offset_monitor #(
  parameter SW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic sample_valid,
  input wire logic [SW-1:0] sample_data,
  input wire logic [2:0] sample_slot,
  input wire logic adj_valid,
  input wire logic [SW-1:0] adj_data,
  input wire logic [2:0] adj_slot
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A sample is taken, and its result shows exactly two edges later.
  sequence s_take; sample_valid; endsequence
  sequence s_out; ##2 adj_valid; endsequence
  ////////////////////////////////////////
  a_ready_now: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_setup_quiet: assert property (psel && !penable |-> !pready)
    else $error("pready high in setup");
  a_err_no_data: assert property (psel && penable && pslverr |-> prdata == 0)
    else $error("error read returned data");
  a_upper_zero: assert property (psel && penable |-> prdata[31:24] == 0)
    else $error("unused read bits set");
  a_out_latency: assert property (s_take |-> s_out)
    else $error("adjusted sample missing");
  a_out_cause: assert property (adj_valid |-> $past(sample_valid, 2))
    else $error("adjusted sample without input");
  a_slot_follow: assert property (s_take |-> ##2 adj_slot == $past(sample_slot, 2))
    else $error("slot lost in pipeline");
  a_unity_pass: assert property (s_take and sample_slot inside {[4:6]} |->
    ##2 adj_data == $past(sample_data, 2))
    else $error("zero offset changed sample");
endmodule
bind channel_gain_offset_regs gain_offset_monitor #(.SW(SW)) gain_offset_monitor_i (.pclk,
  .presetn, .psel, .penable, .pready, .prdata, .pslverr, .sample_valid, .sample_data,
  .sample_slot, .adj_valid, .adj_data, .adj_slot);
`default_nettype wire

// file: verification/sample_sink.sv
// Output data receiver that counts adjusted samples.
`timescale 1ns/1ps
`default_nettype none
module sample_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic adj_valid,
  output logic [31:0] count_q
);
  // The receiver cannot stall the stream, so it only listens.
  always @(posedge pclk or negedge presetn)
    if (!presetn) count_q <= 0;
    else if (adj_valid === 1'b1) count_q <= count_q + 1;
endmodule
`default_nettype wire

// file: verification/channel_gain_offset_regs_tb.sv
// Self-checking bench for the gain and offset bank.
`timescale 1ns/1ps
`default_nettype none
module channel_gain_offset_regs_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sample_valid = 0, er;
  logic [11:0] paddr = 0, sample_data = 0;
  logic [31:0] pwdata = 0, rd;
  logic [2:0] sample_slot = 0;
  wire pready, pslverr, adj_valid;
  wire [31:0] prdata, got;
  wire [11:0] adj_data;
  wire [2:0] adj_slot, adj_input;
  int failures = 0, check_count = 0, cyc = 0, gain, step, d, off[4];
  int sat = 0, seq_rev = 0, in_seen = 0, in_exp = 0;
  int q[$], qs[$];
  channel_gain_offset_regs channel_gain_offset_regs_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(4'hf), .pready, .prdata, .pslverr, .sample_valid,
    .sample_data, .sample_slot, .adj_valid, .adj_data, .adj_slot, .adj_input);
  sample_sink sample_sink_i (.pclk, .presetn, .adj_valid, .count_q(got));
  ////////////////////////////////////////
  always #12.5 pclk = ~pclk;
  // Cut a hang short well past the expected run length.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  // Every adjusted sample is matched against the model in order.
  // The input map lags the slot by one edge, so it is checked only inside streams.
  always @(posedge pclk) begin
    if (adj_valid === 1'b1) begin
      chk("adj_data", {{20{adj_data[11]}}, adj_data}, q.pop_front());
      chk("adj_slot", adj_slot, qs.pop_front());
    end
    if (in_seen) chk("adj_input", adj_input, in_exp);
    in_seen = sample_valid;
    in_exp = seq_rev ? 7 - sample_slot : sample_slot;
  end
  task automatic chk(input string n, input [31:0] s, input [31:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Request is held from setup until pready is seen high.
  task automatic apb(input w, input [11:0] a, input [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdc(input string n, input [11:0] a, input [31:0] e);
    apb(0, a, 0);
    chk(n, rd, e);
  endtask
  // Quarter-LSB sum, signed gain in 1/32 steps, then saturation.
  function automatic int model(int s, int sl);
    int t = s * 4 + ((sl < 4 ? off[sl] : 0) <<< step);
    t = (t * (sl == 7 ? gain : 32)) >>> 7;
    if (t > 2047 || t < -2048) sat = 1;
    return t > 2047 ? 2047 : t < -2048 ? -2048 : t;
  endfunction
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h966741f1));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rdc("gain_reset", 12'h274, 32'h3c);
    for (int i = 0; i < 4; i++) rdc("offset_reset", 12'h278 + 4 * i, 0);
    rdc("step_reset", 12'h29c, 0);
    rdc("sequence_reset", 12'h2a4, 32'hfac688);
    apb(0, 12'h004, 0);
    chk("unmapped_err", er, 1);
    chk("unmapped_data", rd, 0);
    apb(0, 12'h275, 0);
    chk("misaligned_err", er, 1);
    chk("misaligned_data", rd, 0);
    for (int k = 0; k < 4; k++) begin
      step = 3 - k;
      gain = k == 0 ? 127 : k == 1 ? -128 : $urandom_range(255) - 128;
      apb(1, 12'h274, gain & 255);
      rdc("gain", 12'h274, gain & 255);
      apb(1, 12'h29c, step << 3);
      rdc("step", 12'h29c, step << 3);
      // Reverse the sequence halfway: slot n then maps to input 7-n.
      if (k == 2) begin
        apb(1, 12'h2a4, 32'h053977);
        rdc("sequence", 12'h2a4, 32'h053977);
        seq_rev = 1;
      end
      for (int i = 0; i < 4; i++) begin
        off[i] = i == 0 ? 0 : i == 1 ? 1 : i == 2 ? -1 : $urandom_range(255) - 128;
        apb(1, 12'h278 + 4 * i, off[i] & 255);
        rdc("offset", 12'h278 + 4 * i, off[i] & 255);
      end
      // Back-to-back samples over every slot; large codes reach saturation.
      for (int n = 0; n < 40; n++) begin
        @(posedge pclk);
        d = $urandom_range(4095) - 2048;
        sample_valid <= 1;
        sample_slot <= 3'(n);
        sample_data <= 12'(d);
        q.push_back(model(d, n % 8));
        qs.push_back(n % 8);
      end
      @(posedge pclk);
      sample_valid <= 0;
      repeat (4) @(posedge pclk);
      // Sticky saturation follows the model, then clears on a written one.
      rdc("sat_status", 12'h2a8, sat);
      apb(1, 12'h2a8, 1);
      sat = 0;
      rdc("sat_cleared", 12'h2a8, 0);
    end
    chk("sink_count", got, 160);
    print_verdict();
  end
endmodule
`default_nettype wire
